// ==== src/sbalu_core.sv ====
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// (RULE1) Literal subtract writes literal minus accumulator into the accumulator.
// (RULE2) File subtract computes register minus accumulator for register index 0 to 127.
// (RULE3) Destination bit 0 writes the accumulator and leaves the register alone.
// (RULE4) Destination bit 1 writes the register and leaves the accumulator alone.
// (RULE5) Carry is cleared when the subtraction borrows.
// (RULE6) Carry is set when no borrow occurs, including a zero difference.
// (RULE7) Both opcodes decode, run in one cycle and update carry, nibble borrow and zero.
module sbalu_core
  import sbalu_pkg::*;
(
  input  wire logic               clk_i,
  input  wire logic               reset_i,
  input  wire logic               ce_i,
  input  wire logic               instr_valid_i,
  input  wire logic [INSTR_W-1:0] instr_i,
  input  wire logic [DATA_W-1:0]  file_rdata_i,
  output logic      [ADDR_W-1:0]  file_addr_o,
  output logic                    file_we_o,
  output logic      [DATA_W-1:0]  file_wdata_o,
  output logic      [DATA_W-1:0]  acc_o,
  output logic                    carry_flag_o,
  output logic                    nibble_borrow_flag_o,
  output logic                    zero_flag_o,
  output logic                    done_o
);

  // ----------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------
  function automatic logic is_lit_sub(input logic [INSTR_W-1:0] ins);
    return ins[OPC_HI_POS:LIT_OPC_LO] == LIT_SUB_OPC;
  endfunction

  function automatic logic is_file_sub(input logic [INSTR_W-1:0] ins);
    return ins[OPC_HI_POS:FILE_OPC_LO] == FILE_SUB_OPC;
  endfunction

  // Decode happens in the cycle of issue; unknown opcodes pass untouched.
  logic dec_lit;
  logic dec_file;
  logic dest_reg;
  logic go;

  assign dec_lit  = is_lit_sub(instr_i);              // RULE7
  assign dec_file = is_file_sub(instr_i);             // RULE7
  assign dest_reg = instr_i[DEST_POS];
  assign go       = ce_i & instr_valid_i & (dec_lit | dec_file);

  // ----------------------------------------------------------------------
  // Datapath
  // ----------------------------------------------------------------------
  // The register file read is combinational on the index, so the whole
  // operation fits in one cycle at the cost of an async read path.
  logic [DATA_W-1:0] minuend;
  logic [DATA_W-1:0] diff;
  logic              c_nxt;
  logic              nb_nxt;
  logic              z_nxt;

  assign file_addr_o = instr_i[ADDR_W-1:0];                       // RULE2
  assign minuend     = dec_lit ? instr_i[DATA_W-1:0] : file_rdata_i; // RULE1

  sbalu_sub8 u_sub (
    .minuend_i      (minuend),
    .subtrahend_i   (acc_o),
    .diff_o         (diff),
    .carry_o        (c_nxt),
    .nibble_carry_o (nb_nxt),
    .zero_o         (z_nxt)
  );

  // Register write-back is a combinational strobe on the issue cycle.
  assign file_we_o    = go & dec_file & dest_reg;   // RULE4
  assign file_wdata_o = diff;

  // ----------------------------------------------------------------------
  // Accumulator and flags
  // ----------------------------------------------------------------------
  logic acc_we;

  assign acc_we = go & (dec_lit | ~dest_reg);       // RULE1 RULE3

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      acc_o <= ACC_RST;
    end else if (acc_we) begin
      acc_o <= diff;
    end
  end

  // Carry is the inverted borrow, so zero difference leaves it set.
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      carry_flag_o         <= FLAG_RST;
      nibble_borrow_flag_o <= FLAG_RST;
      zero_flag_o          <= FLAG_RST;
    end else if (go) begin
      carry_flag_o         <= c_nxt;                // RULE5 RULE6
      nibble_borrow_flag_o <= nb_nxt;               // RULE7
      zero_flag_o          <= z_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Completion state
  // ----------------------------------------------------------------------
  sbalu_state_t state_r;
  sbalu_state_t state_nxt;

  always_comb begin
    case (state_r)
      SBALU_IDLE: state_nxt = go ? SBALU_EXEC : SBALU_IDLE;
      SBALU_EXEC: state_nxt = go ? SBALU_EXEC : SBALU_IDLE;
      default:    state_nxt = SBALU_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_r <= SBALU_IDLE;
    end else if (ce_i) begin
      state_r <= state_nxt;
    end
  end

  // Done marks the cycle after issue, when results are visible.
  assign done_o = (state_r == SBALU_EXEC);

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  logic [DATA_W:0] exp_full;
  assign exp_full = {1'b0, minuend} - {1'b0, acc_o};

  sequence s_issue_lit;
    go && dec_lit;
  endsequence

  property p_lit_result;
    @(posedge clk_i) disable iff (reset_i)
      s_issue_lit |=> acc_o == $past(instr_i[7:0]) - $past(acc_o);
  endproperty
  a_lit_result: assert property (p_lit_result) // RULE1
    else $error("literal subtract result wrong");

  property p_file_wdata;
    @(posedge clk_i) disable iff (reset_i)
      file_we_o |-> file_wdata_o == file_rdata_i - acc_o && file_addr_o == instr_i[6:0];
  endproperty
  a_file_wdata: assert property (p_file_wdata) // RULE2
    else $error("file subtract write data wrong");

  property p_dest_acc;
    @(posedge clk_i) disable iff (reset_i)
      go && dec_file && !dest_reg |-> !file_we_o ##1 acc_o == $past(file_rdata_i) - $past(acc_o);
  endproperty
  a_dest_acc: assert property (p_dest_acc) else $error("destination 0 handled wrong"); // RULE3

  property p_dest_reg;
    @(posedge clk_i) disable iff (reset_i)
      go && dec_file && dest_reg |-> file_we_o ##1 $stable(acc_o);
  endproperty
  a_dest_reg: assert property (p_dest_reg) // RULE4
    else $error("destination 1 changed accumulator");

  property p_borrow_clears;
    @(posedge clk_i) disable iff (reset_i)
      go && exp_full[DATA_W] |=> !carry_flag_o;
  endproperty
  a_borrow_clears: assert property (p_borrow_clears) // RULE5
    else $error("carry not cleared on borrow");

  property p_noborrow_sets;
    @(posedge clk_i) disable iff (reset_i)
      go && !exp_full[DATA_W] |=> carry_flag_o
                                  && (zero_flag_o == ($past(exp_full[7:0]) == 8'h00));
  endproperty
  a_noborrow_sets: assert property (p_noborrow_sets) // RULE6
    else $error("carry not set without borrow");

  property p_nibble;
    @(posedge clk_i) disable iff (reset_i)
      go |=> nibble_borrow_flag_o == ($past(minuend[3:0]) >= $past(acc_o[3:0]));
  endproperty
  a_nibble: assert property (p_nibble) else $error("nibble borrow flag wrong"); // RULE7

  property p_one_cycle;
    @(posedge clk_i) disable iff (reset_i)
      go |=> done_o;
  endproperty
  a_one_cycle: assert property (p_one_cycle) // RULE7
    else $error("done not one cycle after issue");

  property p_idle_hold;
    @(posedge clk_i) disable iff (reset_i)
      !go |=> $stable(acc_o) && $stable(carry_flag_o);
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("state moved without issue"); // RULE7

  // Clock enable low must hold the flags and done as well as the accumulator.
  property p_ce_freeze;
    @(posedge clk_i) disable iff (reset_i)
      !ce_i |=> $stable(acc_o) && $stable(carry_flag_o) && $stable(nibble_borrow_flag_o)
                && $stable(zero_flag_o) && $stable(done_o);
  endproperty
  a_ce_freeze: assert property (p_ce_freeze) // RULE7
    else $error("state moved with clock enable low");

  // Judged from the raw instruction bits so a decode slip cannot hide a stray write.
  property p_no_stray_write;
    @(posedge clk_i) disable iff (reset_i)
      !ce_i || !instr_valid_i || !instr_i[DEST_POS]
      || instr_i[OPC_HI_POS:FILE_OPC_LO] != FILE_SUB_OPC |-> !file_we_o;
  endproperty
  a_no_stray_write: assert property (p_no_stray_write) // RULE3
    else $error("write strobe without file subtract to register");

  // Zero follows the operands themselves, not the subtractor output.
  property p_zero_flag;
    @(posedge clk_i) disable iff (reset_i)
      go |=> zero_flag_o == ($past(minuend) == $past(acc_o));
  endproperty
  a_zero_flag: assert property (p_zero_flag) // RULE7
    else $error("zero flag wrong");

  sequence s_issue_file;
    go && dec_file;
  endsequence

  // Literal issue: carry says whether the literal covers the accumulator.
  property p_lit_carry;
    @(posedge clk_i) disable iff (reset_i)
      s_issue_lit |=> carry_flag_o == ($past(instr_i[7:0]) >= $past(acc_o));
  endproperty
  a_lit_carry: assert property (p_lit_carry) // RULE5 RULE6
    else $error("literal subtract carry wrong");

  // File issue: carry says whether the register covers the accumulator.
  property p_file_carry;
    @(posedge clk_i) disable iff (reset_i)
      s_issue_file |=> carry_flag_o == ($past(file_rdata_i) >= $past(acc_o));
  endproperty
  a_file_carry: assert property (p_file_carry) // RULE2
    else $error("file subtract carry wrong");

  // An enabled cycle without issue must end the done pulse.
  property p_done_drop;
    @(posedge clk_i) disable iff (reset_i)
      ce_i && !go |=> !done_o;
  endproperty
  a_done_drop: assert property (p_done_drop) // RULE7
    else $error("done held without issue");

endmodule

`default_nettype wire

// ==== src/sbalu_pkg.sv ====
`default_nettype none

package sbalu_pkg;

  // ----------------------------------------------------------------------
  // Widths and instruction encoding
  // ----------------------------------------------------------------------
  localparam int unsigned DATA_W      = 8;
  localparam int unsigned ADDR_W      = 7;
  localparam int unsigned INSTR_W     = 14;
  localparam int unsigned OPC_HI_POS  = 13;
  localparam int unsigned DEST_POS    = 7;
  localparam int unsigned LIT_OPC_LO  = 9;
  localparam int unsigned FILE_OPC_LO = 8;

  // Literal subtract matches bits 13:9, bit 8 is a don't-care.
  localparam logic [4:0] LIT_SUB_OPC  = 5'h1e;
  // File subtract matches bits 13:8.
  localparam logic [5:0] FILE_SUB_OPC = 6'h02;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] ACC_RST  = 8'h00;
  localparam logic       FLAG_RST = 1'b0;

  // Execution state, one-hot.
  typedef enum logic [1:0] {
    SBALU_IDLE = 2'b01,
    SBALU_EXEC = 2'b10
  } sbalu_state_t;

endpackage

`default_nettype wire

// ==== src/sbalu_sub8.sv ====
`timescale 1ns/10ps
`default_nettype none

// Combinational two's complement subtractor: minuend minus subtrahend.
module sbalu_sub8
  import sbalu_pkg::*;
(
  input  wire logic [DATA_W-1:0] minuend_i,
  input  wire logic [DATA_W-1:0] subtrahend_i,
  output logic      [DATA_W-1:0] diff_o,
  output logic                   carry_o,
  output logic                   nibble_carry_o,
  output logic                   zero_o
);

  // ----------------------------------------------------------------------
  // Adder form
  // ----------------------------------------------------------------------
  // Adding the inverted subtrahend plus one makes the carry out an active
  // low borrow, which is exactly the carry flag convention wanted.
  logic [DATA_W:0] full_sum;
  logic [4:0]      low_sum;

  assign full_sum       = {1'b0, minuend_i} + {1'b0, ~subtrahend_i} + 9'h001;
  assign low_sum        = {1'b0, minuend_i[3:0]} + {1'b0, ~subtrahend_i[3:0]} + 5'h01;
  assign diff_o         = full_sum[DATA_W-1:0];
  assign carry_o        = full_sum[DATA_W];
  assign nibble_carry_o = low_sum[4];
  assign zero_o         = (full_sum[DATA_W-1:0] == 8'h00);

endmodule

`default_nettype wire

// ==== test/sbalu_tb.sv ====
`timescale 1ns/10ps
`default_nettype none

module testbench;
  import sbalu_pkg::*;

  // ----------------------------------------------------------------------
  // Stimulus, observed outputs and the reference model state
  // ----------------------------------------------------------------------
  logic        clk_i, reset_i, ce_i, instr_valid_i;
  logic [13:0] instr_i;
  logic [7:0]  file_rdata_i, file_wdata_o, acc_o, acc_m, dif, mn;
  logic [6:0]  file_addr_o;
  logic        file_we_o, carry_flag_o, nibble_borrow_flag_o, zero_flag_o, done_o;
  logic        c_m, n_m, z_m, d_m;
  int          err_count, n_checks;

  sbalu_core sbalu_core_inst (.clk_i(clk_i), .reset_i(reset_i), .ce_i(ce_i),
    .instr_valid_i(instr_valid_i), .instr_i(instr_i), .file_rdata_i(file_rdata_i),
    .file_addr_o(file_addr_o), .file_we_o(file_we_o), .file_wdata_o(file_wdata_o),
    .acc_o(acc_o), .carry_flag_o(carry_flag_o), .done_o(done_o),
    .nibble_borrow_flag_o(nibble_borrow_flag_o), .zero_flag_o(zero_flag_o));

  // The 25 MHz core clock.
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  // Flags are passed zero-extended, so an unknown bit still fails the match.
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // One cycle per call. Registers are checked against the previous call's
  // effect, so back-to-back calls also exercise issue on every edge.
  task automatic op(input logic [13:0] ins, input logic [7:0] rd, input logic ce,
                    input logic v);
    logic lit, fil, tk;
    @(posedge clk_i);
    ce_i          <= ce;
    instr_valid_i <= v;
    instr_i       <= ins;
    file_rdata_i  <= rd;
    @(negedge clk_i);
    chk("acc", acc_o, acc_m);
    chk("carry", carry_flag_o, c_m);
    chk("nibble", nibble_borrow_flag_o, n_m);
    chk("zero", zero_flag_o, z_m);
    chk("done", done_o, d_m);
    lit = ins[13:9] == 5'h1e;
    fil = ins[13:8] == 6'h02;
    tk  = ce & v & (lit | fil);
    mn  = lit ? ins[7:0] : rd;
    dif = mn - acc_m;
    chk("addr", file_addr_o, ins[6:0]);
    chk("we", file_we_o, tk & fil & ins[7]);
    if (tk & fil & ins[7]) chk("wdata", file_wdata_o, dif);
    if (tk) begin
      c_m = mn >= acc_m;
      n_m = mn[3:0] >= acc_m[3:0];
      z_m = dif == 8'h00;
      if (!(fil & ins[7])) acc_m = dif;
    end
    // A low clock enable freezes the completion flag as well.
    if (ce) d_m = tk;
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_literal;
    logic [13:0] lits [7] = '{14'h3c01, 14'h3c02, 14'h3d01, 14'h3c03, 14'h3d00,
                              14'h3c10, 14'h3cff};
    foreach (lits[i]) op(lits[i], 8'h5a, 1'b1, 1'b1);
    op(14'h0000, 8'h00, 1'b1, 1'b0);
    $display("literal subtract done");
  endtask

  // The first three minuends are taken from the model so zero and borrow cases are exact.
  task automatic t_file;
    op(14'h02ff, acc_m + 8'h01, 1'b1, 1'b1);
    op(14'h0280, acc_m, 1'b1, 1'b1);
    op(14'h0255, acc_m - 8'h01, 1'b1, 1'b1);
    op(14'h027f, 8'h80, 1'b1, 1'b1);
    op(14'h0000, 8'h00, 1'b1, 1'b0);
    $display("file subtract done");
  endtask

  // Frozen, foreign and non-valid words must leave the accumulator, the flags and the write strobe alone.
  task automatic t_refused;
    op(14'h02a3, 8'h11, 1'b0, 1'b1);
    op(14'h3a0f, 8'h22, 1'b1, 1'b1);
    op(14'h0300, 8'h33, 1'b1, 1'b1);
    op(14'h3c07, 8'h44, 1'b1, 1'b0);
    op(14'h0000, 8'h00, 1'b1, 1'b0);
    $display("refused issue done");
  endtask

  // A reset in mid-run clears at once, without waiting for an edge, and the
  // block takes a new issue right after release.
  task automatic t_reset;
    op(14'h3cff, 8'h00, 1'b1, 1'b1);
    op(14'h0000, 8'h00, 1'b1, 1'b0);
    @(posedge clk_i);
    reset_i <= 1'b1;
    @(negedge clk_i);
    chk("rst acc", acc_o, 8'h00);
    chk("rst flags", {4'h0, carry_flag_o, nibble_borrow_flag_o, zero_flag_o, done_o}, 8'h00);
    @(posedge clk_i);
    reset_i <= 1'b0;
    acc_m = 8'h00;
    {c_m, n_m, z_m, d_m} = 4'h0;
    op(14'h3c05, 8'h00, 1'b1, 1'b1);
    op(14'h0000, 8'h00, 1'b1, 1'b0);
    $display("mid-run reset done");
  endtask

  // ----------------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------------
  initial begin
    reset_i       = 1'b1;
    ce_i          = 1'b0;
    instr_valid_i = 1'b0;
    instr_i       = 14'h0000;
    file_rdata_i  = 8'h00;
    acc_m         = 8'h00;
    {c_m, n_m, z_m, d_m} = 4'h0;
    repeat (3) @(posedge clk_i);
    reset_i <= 1'b0;
    op(14'h0000, 8'h00, 1'b1, 1'b0);
    $display("reset values done");
    t_literal();
    t_file();
    t_refused();
    t_reset();
    conclude();
  end

  // A hang is cut short well beyond the few dozen cycles the run needs.
  initial begin
    repeat (2000) @(posedge clk_i);
    err_count++;
    conclude();
  end

endmodule

`default_nettype wire
